/* rtl/rsi_pkg.sv */
// Purpose: shared constants and types for the reset state initializer
// Assumes: 32-bit APB, byte addressing, one register per aligned word
// Notes: power control is addressed by word index; its byte address is four times it
package rsi_pkg;
  // register byte addresses and indices
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_PC = 12'h008;
  localparam logic [11:0] ADDR_WAKE = 12'h00C;
  localparam logic [9:0] IDX_POWER_CONTROL = 10'h08E;
  localparam logic [11:0] ADDR_POWER_CONTROL = {IDX_POWER_CONTROL, 2'b00};

  // core status fields
  localparam int ST_BANK_LSB = 5;
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam logic [7:0] STATUS_RST = 8'h18;
  // power control fields
  localparam int PC_BOR = 0;
  localparam int PC_POR = 1;
  localparam logic [1:0] POWER_CONTROL_RST = 2'h0;
  // control fields
  localparam int CT_SLEEP = 0;
  localparam int CT_GIE = 1;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_VECTOR = 16'h0004;

  typedef enum logic [2:0] {
    RSI_RUN = 3'b001,
    RSI_SLEEP = 3'b010,
    RSI_VEC = 3'b100
  } rsi_state_t;

  typedef enum logic [5:0] {
    RSI_K_NONE = 6'b000000,
    RSI_K_POR = 6'b000001,
    RSI_K_BOR = 6'b000010,
    RSI_K_MASTER_CLEAR_PIN = 6'b000100,
    RSI_K_WDT = 6'b001000,
    RSI_K_IRQ = 6'b010000,
    RSI_K_UNUSED = 6'b100000
  } rsi_kind_t;

  // reset and wake sources from outside the clock domain
  typedef struct packed {
    logic por;
    logic bor;
    logic master_clear_pin;
    logic wdt;
    logic irq;
  } rsi_evt_t;

  // pending interrupt flags: control, peripheral group 1, peripheral group 2
  typedef struct packed {
    logic ctl;
    logic per1;
    logic per2;
  } rsi_src_t;
endpackage

/* rtl/rsi_reset_init.sv */
// Purpose: decides program counter, core status and power control after resets and wakes
// Assumes: event inputs are asynchronous levels; a rising edge is one event
// Notes: unknown arithmetic flags are left as they were
`timescale 1ns/1ns
module rsi_reset_init #(
  parameter int PC_W = 13
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire rsi_pkg::rsi_evt_t evt_in, // reset and wake sources
  input wire rsi_pkg::rsi_src_t src_in, // pending interrupt flags
  output logic [PC_W-1:0] pc, // program counter
  output logic [7:0] status, // core status register
  output logic [1:0] power_control, // power control flags
  output logic asleep // core is sleeping
);
  import rsi_pkg::*;

  // the vector needs three bits; the reset and vector constants are sixteen bits wide
  if (PC_W < 3 || PC_W > 16) begin : g_pc_w_check
    $error("PC_W must lie between 3 and 16");
  end

  rsi_evt_t evt_s1, evt_s2, evt_d;
  rsi_src_t src_s1, src_s2;
  rsi_evt_t evt_edge, evt_take;
  rsi_state_t state;
  rsi_kind_t kind;
  logic global_irq_enable;
  logic [2:0] wake_src;
  logic acc, wr, mapped, irq_go;

  function automatic rsi_kind_t pick_kind(input rsi_evt_t e, input logic sleeping);
    pick_kind = RSI_K_NONE;
    if (e.por) begin
      pick_kind = RSI_K_POR;
    end else if (e.bor) begin
      pick_kind = RSI_K_BOR;
    end else if (e.master_clear_pin) begin
      pick_kind = RSI_K_MASTER_CLEAR_PIN;
    end else if (e.wdt) begin
      pick_kind = RSI_K_WDT;
    end else if (e.irq && sleeping) begin
      pick_kind = RSI_K_IRQ;
    end
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ADDR_STATUS) || (a == ADDR_CTRL) || (a == ADDR_PC) ||
      (a == ADDR_WAKE) || (a == ADDR_POWER_CONTROL);
  endfunction

  // two flops before any logic reads the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_s1 <= '0;
      evt_s2 <= '0;
      evt_d <= '0;
      src_s1 <= '0;
      src_s2 <= '0;
    end else begin
      evt_s1 <= evt_in;
      evt_s2 <= evt_s1;
      evt_d <= evt_s2;
      src_s1 <= src_in;
      src_s2 <= src_s1;
    end
  end

  assign evt_edge = evt_s2 & ~evt_d;
  // a wake with no pending source is dropped so a flag is always left
  assign irq_go = evt_edge.irq && (src_s2 != '0);
  assign evt_take = {evt_edge.por, evt_edge.bor, evt_edge.master_clear_pin, evt_edge.wdt,
    irq_go};
  assign kind = pick_kind(evt_take, state == RSI_SLEEP);
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && mapped;
  assign mapped = is_mapped(paddr);

  // apb: ready one cycle after setup, data loaded with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_STATUS: prdata[7:0] <= status;
          ADDR_CTRL: prdata[CT_GIE:0] <= {global_irq_enable, asleep};
          ADDR_PC: prdata[PC_W-1:0] <= pc;
          ADDR_WAKE: prdata[2:0] <= wake_src;
          ADDR_POWER_CONTROL: prdata[1:0] <= power_control;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !mapped) |-> (prdata == 32'h0000_0000 && pslverr))
    else $error("unmapped access returned data or no error");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RSI_RUN;
    end else begin
      case (kind)
        RSI_K_POR, RSI_K_BOR, RSI_K_MASTER_CLEAR_PIN: state <= RSI_RUN;
        RSI_K_WDT: state <= RSI_RUN;
        RSI_K_IRQ: state <= global_irq_enable ? RSI_VEC : RSI_RUN;
        default: begin
          case (state)
            RSI_RUN: begin
              if (wr && paddr == ADDR_CTRL && pwdata[CT_SLEEP]) begin
                state <= RSI_SLEEP;
              end
            end
            RSI_SLEEP: state <= RSI_SLEEP;
            RSI_VEC: state <= RSI_RUN;
            default: state <= RSI_RUN;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asleep <= 1'b0;
    end else begin
      asleep <= (state == RSI_SLEEP) && (kind == RSI_K_NONE) ||
        (state == RSI_RUN) && kind == RSI_K_NONE && wr && paddr == ADDR_CTRL &&
        pwdata[CT_SLEEP];
    end
  end

  // interrupts disabled by any reset and by taking the vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0;
    end else if (kind == RSI_K_POR || kind == RSI_K_BOR || kind == RSI_K_MASTER_CLEAR_PIN ||
      (kind == RSI_K_WDT && state != RSI_SLEEP)) begin
      global_irq_enable <= 1'b0;
    end else if (state == RSI_VEC) begin
      global_irq_enable <= 1'b0;
    end else if (wr && paddr == ADDR_CTRL) begin
      global_irq_enable <= pwdata[CT_GIE];
    end
  end

  a_vec_gie: assert property (@(posedge pclk) disable iff (!presetn)
    (state == RSI_VEC && kind == RSI_K_NONE) |=>
    (!global_irq_enable && state == RSI_RUN && pc == PC_W'(PC_VECTOR)))
    else $error("vector step did not load vector and clear enable");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= PC_W'(PC_RESET);
    end else begin
      case (kind)
        RSI_K_POR, RSI_K_BOR: pc <= PC_W'(PC_RESET);
        RSI_K_MASTER_CLEAR_PIN: pc <= PC_W'(PC_RESET);
        RSI_K_WDT: pc <= (state == RSI_SLEEP) ? PC_W'(pc + 1'b1) : PC_W'(PC_RESET);
        RSI_K_IRQ: pc <= PC_W'(pc + 1'b1);
        default: begin
          if (state == RSI_VEC) begin
            pc <= PC_W'(PC_VECTOR);
          end else if (wr && paddr == ADDR_PC) begin
            pc <= pwdata[PC_W-1:0];
          end
        end
      endcase
    end
  end

  // timeout and powerdown are not writable by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STATUS_RST;
    end else begin
      case (kind)
        RSI_K_POR, RSI_K_BOR: status <= {3'b000, 1'b1, 1'b1, status[2:0]};
        RSI_K_MASTER_CLEAR_PIN: begin
          if (state == RSI_SLEEP) begin
            status <= {3'b000, 1'b1, 1'b0, status[2:0]};
          end else begin
            status <= {3'b000, status[ST_TO:0]};
          end
        end
        RSI_K_WDT: begin
          if (state == RSI_SLEEP) begin
            status <= {status[7:ST_BANK_LSB], 1'b0, 1'b0, status[2:0]};
          end else begin
            status <= {3'b000, 1'b0, status[ST_PD:0]};
          end
        end
        RSI_K_IRQ: status <= {status[7:ST_BANK_LSB], 1'b1, 1'b0, status[2:0]};
        default: begin
          if (wr && paddr == ADDR_STATUS) begin
            status <= {pwdata[7:ST_BANK_LSB], status[ST_TO:ST_PD], pwdata[2:0]};
          end
        end
      endcase
    end
  end

  a_bor_init: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_BOR) |=>
    (pc == '0 && status[7:3] == 5'b00011 && power_control[PC_BOR] == 1'b0))
    else $error("brown-out did not load pc and status");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control <= POWER_CONTROL_RST;
    end else if (kind == RSI_K_POR) begin
      power_control <= {1'b0, power_control[PC_BOR]};
    end else if (kind == RSI_K_BOR) begin
      power_control <= {power_control[PC_POR], 1'b0};
    end else if (kind == RSI_K_NONE && wr && paddr == ADDR_POWER_CONTROL) begin
      power_control <= pwdata[1:0];
    end
  end

  a_power_control_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_MASTER_CLEAR_PIN || kind == RSI_K_WDT || kind == RSI_K_IRQ) |=>
    (power_control == $past(power_control)))
    else $error("power control flags changed on reset or wake");

  // write one to clear; a new source in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_src <= 3'h0;
    end else if (kind == RSI_K_IRQ) begin
      wake_src <= wake_src | src_s2;
    end else if (wr && paddr == ADDR_WAKE) begin
      wake_src <= wake_src & ~pwdata[2:0];
    end
  end

  a_wake_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_IRQ) |=> ((wake_src & $past(src_s2)) == $past(src_s2)))
    else $error("wake source flag not recorded");

  a_por_init: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_POR) |=> (pc == '0 && status[7:3] == 5'b00011))
    else $error("power-on did not load pc and status");
  a_master_clear_pin_run: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_MASTER_CLEAR_PIN && state == RSI_RUN) |=>
    (pc == '0 && status[7:5] == 3'b000 && status[4:0] == $past(status[4:0]) &&
    power_control == $past(power_control)))
    else $error("running master clear changed kept bits");
  a_master_clear_pin_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_MASTER_CLEAR_PIN && state == RSI_SLEEP) |=>
    (status[7:3] == 5'b00010 && status[2:0] == $past(status[2:0])))
    else $error("sleeping master clear gave wrong status");
  a_irq_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_IRQ) |=> (pc == PC_W'($past(pc) + 1'b1) && status[4:3] == 2'b10 &&
    status[7:5] == $past(status[7:5]) && power_control == $past(power_control)))
    else $error("interrupt wake did not resume at next address");
  a_vector_go: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_IRQ && global_irq_enable) |=> (pc == PC_W'($past(pc) + 1'b1)) ##1
    (pc == PC_W'(PC_VECTOR) && !global_irq_enable))
    else $error("vector not taken after next instruction");
  a_bor_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (kind != RSI_K_NONE) |=> (power_control[PC_BOR] == ($past(kind) == RSI_K_BOR ? 1'b0 :
    $past(power_control[PC_BOR]))))
    else $error("brownout flag wrong after reset");
  a_wdt_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_WDT && state != RSI_SLEEP) |=> (pc == '0 && status[7:4] == 4'h0 &&
    status[3:0] == $past(status[3:0])))
    else $error("watchdog reset gave wrong status");
  a_wdt_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_WDT && state == RSI_SLEEP) |=> (status[4:3] == 2'b00 && state == RSI_RUN))
    else $error("watchdog wake gave wrong status");
  a_por_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (evt_edge.por && (evt_edge.master_clear_pin || evt_edge.wdt || evt_edge.bor)) |=>
    (status[4:3] == 2'b11 && power_control[PC_POR] == 1'b0))
    else $error("power-on did not override other reset");
  a_wake_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_IRQ) |=> (wake_src != 3'h0))
    else $error("interrupt wake left no source flag");
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && paddr == ADDR_POWER_CONTROL) |-> (prdata[31:2] == 30'h0))
    else $error("unimplemented bits read nonzero");
  a_por_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == RSI_K_BOR || kind == RSI_K_MASTER_CLEAR_PIN || kind == RSI_K_WDT) |=>
    (power_control[PC_POR] == $past(power_control[PC_POR])))
    else $error("power_on_flag changed on non power-on reset");
endmodule

/* verification/rsi_reset_init_bench.sv */
// Purpose: self-checking bench for the reset state initializer
// Assumes: apb answers in the cycle after setup; events act three edges after rising
// Notes: read results are queued by the driver and compared by a watching process
`timescale 1ns/1ns
module rsi_reset_init_bench;
  import rsi_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, asleep;
  rsi_evt_t evt_in = '0;
  rsi_src_t src_in = '0;
  logic [12:0] pc;
  logic [7:0] status;
  logic [1:0] power_control;
  int fail_count = 0;
  int n_compared = 0;
  logic [32:0] exp_q[$];
  logic [2:0] a, s;
  logic [12:0] p;
  int n;

  rsi_reset_init #(.PC_W(13)) i_rsi_reset_init (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt_in(evt_in), .src_in(src_in), .pc(pc),
    .status(status), .power_control(power_control), .asleep(asleep));

  always #25 pclk = ~pclk;

  task automatic check(logic [32:0] seen, logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hold the request until pready is seen at a rising edge
  task automatic xfer(logic w, logic [11:0] ad, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fail_count++;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(logic [11:0] ad, logic [31:0] d);
    xfer(1, ad, d);
  endtask

  task automatic rd(logic [11:0] ad, logic [31:0] d, logic e = 0);
    exp_q.push_back({e, d});
    xfer(0, ad, 32'h0);
  endtask

  // pulse event bits long enough for the two-flop synchronizer
  task automatic ev(logic [4:0] m);
    @(posedge pclk);
    evt_in <= rsi_evt_t'(evt_in | m);
    repeat (6) @(posedge pclk);
    evt_in <= rsi_evt_t'(evt_in & ~m);
    repeat (4) @(posedge pclk);
  endtask

  function automatic logic [31:0] st(logic [2:0] b, logic t, logic d);
    return {24'h0, b, t, d, a};
  endfunction

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  initial begin
    #250000;
    fail_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(51884));
    a = 3'($urandom);
    s = 3'($urandom) | 3'h1;
    p = 13'($urandom) & 13'h0fff;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(ADDR_STATUS, 32'h18);
    rd(ADDR_POWER_CONTROL, 32'h0);
    rd(ADDR_PC, 32'h0);
    rd(12'h010, 32'h0, 1);
    wr(ADDR_STATUS, st(3'h7, 0, 0));
    rd(ADDR_STATUS, st(3'h7, 1, 1));
    wr(ADDR_POWER_CONTROL, 32'hffff_ffff);
    rd(ADDR_POWER_CONTROL, 32'h3);
    wr(ADDR_PC, {19'h0, p});
    ev(5'b00100);
    rd(ADDR_PC, 32'h0);
    rd(ADDR_STATUS, st(3'h0, 1, 1));
    rd(ADDR_POWER_CONTROL, 32'h3);
    wr(ADDR_STATUS, st(3'h7, 0, 0));
    ev(5'b00010);
    rd(ADDR_PC, 32'h0);
    rd(ADDR_STATUS, st(3'h0, 0, 1));
    ev(5'b01000);
    rd(ADDR_STATUS, st(3'h0, 1, 1));
    rd(ADDR_POWER_CONTROL, 32'h2);
    wr(ADDR_POWER_CONTROL, 32'h3);
    wr(ADDR_STATUS, st(3'h5, 0, 0));
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_CTRL, 32'h1);
    ev(5'b00100);
    rd(ADDR_STATUS, st(3'h0, 1, 0));
    rd(ADDR_POWER_CONTROL, 32'h3);
    wr(ADDR_STATUS, st(3'h5, 0, 0));
    wr(ADDR_PC, {19'h0, p});
    wr(ADDR_CTRL, 32'h1);
    ev(5'b00010);
    rd(ADDR_PC, {19'h0, p + 13'h1});
    rd(ADDR_STATUS, st(3'h5, 0, 0));
    // interrupt with no pending flag must not wake
    wr(ADDR_PC, {19'h0, p});
    wr(ADDR_CTRL, 32'h1);
    ev(5'b00001);
    rd(ADDR_CTRL, 32'h1);
    src_in <= rsi_src_t'(s);
    ev(5'b00001);
    rd(ADDR_PC, {19'h0, p + 13'h1});
    rd(ADDR_STATUS, st(3'h5, 1, 0));
    rd(ADDR_WAKE, {29'h0, s});
    rd(ADDR_POWER_CONTROL, 32'h3);
    ev(5'b00001);
    rd(ADDR_PC, {19'h0, p + 13'h1});
    src_in <= '0;
    wr(ADDR_WAKE, 32'h7);
    rd(ADDR_WAKE, 32'h0);
    wr(ADDR_PC, {19'h0, p});
    src_in <= rsi_src_t'(s);
    wr(ADDR_CTRL, 32'h3);
    @(posedge pclk);
    evt_in <= rsi_evt_t'(5'b00001);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (asleep !== 1'b0 && n < 20);
    if (n >= 20) fail_count++;
    check({20'h0, pc}, {20'h0, p + 13'h1});
    @(posedge pclk);
    #1;
    check({20'h0, pc}, {20'h0, PC_VECTOR[12:0]});
    @(posedge pclk);
    evt_in <= '0;
    rd(ADDR_CTRL, 32'h0);
    // power-on wins over a master clear raised with it
    wr(ADDR_POWER_CONTROL, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    ev(5'b10100);
    rd(ADDR_STATUS, st(3'h0, 1, 1));
    rd(ADDR_POWER_CONTROL, 32'h1);
    rd(ADDR_CTRL, 32'h0);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(ADDR_STATUS, 32'h18);
    rd(ADDR_POWER_CONTROL, 32'h0);
    repeat (4) @(posedge pclk);
    give_verdict();
  end
endmodule
